// [sct_slow_counter.sv]
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// R1: Counter interrupt output is shared by wrap and match sources.
// R2: Separate tick interrupt output, raised each time the chosen tick interval elapses.
// R3: Wrap occurs when the counter at top value returns to zero.
// R4: Match occurs when the counter equals the match value.
// R5: Every condition sets its flag, enabled or not.
// R6: Each source has its own software enable bit.
// R7: Request is high while enable and flag are both set.
// R8: Counter keeps running in Idle sleep.
// R9: In Standby the counter runs only if keep_running_asleep is set.
// R10: Tick timer runs in every sleep mode regardless of keep_running_asleep.
// R11: Counting runs on the slow clock; register updates act after synchronisation.
// R12: Status shows four busy bits: match, top, count, control.
// R13: Tick status shows one busy bit for the tick control register.
// R14: Software waits for a busy bit to clear before rewriting that register.
// R15: Prescale field bits 6:3 divides the slow clock by two to that power.
// R16: Control write acts two slow clock edges later, busy covers that.
// R17: Control bit 0 enables the counter; control resets to zero.
// R18: Status bit 3 is high while the match value is synchronising.
// R19: Writing one clears a flag, writing zero leaves it.
// R20: Wrap is detected when counter matches top value then goes to zero.
// R21: Counter advances one per divided tick while enabled, holds while disabled.
// R22: Busy bits set on the bus write, clear once the value acts.
module sct_slow_counter (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Slow count clock, sampled as a level.
    input wire logic slow_clk_in,
    // System state.
    input wire logic sleep_idle,
    input wire logic sleep_standby,
    input wire logic debug_halt,
    // Interrupt requests and events.
    output logic irq_counter,
    output logic irq_tick,
    output logic wrap_event,
    output logic match_event,
    output logic [1:0] clock_source
);

    logic ap_take;
    logic dp_wr_q;
    logic [5:0] dp_idx_q;
    logic [5:0] ap_idx;
    localparam int NSYNC_W = sct_pkg::NSYNC;
    logic [31:0] rd_mux;
    logic [NSYNC_W-1:0] sync_wr;
    logic [NSYNC_W-1:0] sync_done;
    logic [NSYNC_W-1:0] pending_q;

    sct_pkg::sct_ctrl_t ctrl_q;
    sct_pkg::sct_ctrl_t ctrl_e_q;
    sct_pkg::sct_tick_ctrl_t tick_ctrl_q;
    sct_pkg::sct_tick_ctrl_t tick_e_q;
    logic [15:0] cnt_wr_q;
    logic [15:0] count_q;
    logic [15:0] top_q;
    logic [15:0] top_e_q;
    logic [15:0] match_q;
    logic [15:0] match_e_q;
    logic [1:0] cen_q;
    logic [1:0] cflags_q;
    logic ten_q;
    logic tflag_q;
    logic [7:0] latch_q;
    logic run_halted_q;
    logic tick_run_halted_q;
    logic [1:0] clk_src_q;

    logic slow_q;
    logic slow_edge;
    logic [15:0] presc_q;
    logic [15:0] div_mask;
    logic div_hit;
    logic counter_run;
    logic tick_run;
    logic count_tick;
    logic wrap_c;
    logic match_c;
    logic tick_bit_q;
    logic tick_hit;
    logic [1:0] cflag_clr;
    logic tflag_clr;

    // Bus slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_take = hsel && htrans == sct_pkg::HTRANS_NONSEQ && hready;
    assign ap_idx = haddr[sct_pkg::ADDR_MSB:sct_pkg::ADDR_LSB];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_idx_q <= 6'h00;
        end else begin
            dp_wr_q <= ap_take && hwrite;
            dp_idx_q <= ap_idx;
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case (ap_idx)
            sct_pkg::IDX_CTRL: rd_mux[7:0] = ctrl_q;
            sct_pkg::IDX_STATUS: rd_mux[3:0] = pending_q[3:0]; // R12
            sct_pkg::IDX_IRQ_EN: rd_mux[1:0] = cen_q;
            sct_pkg::IDX_IRQ_FLAGS: rd_mux[1:0] = cflags_q;
            sct_pkg::IDX_BYTE_LATCH: rd_mux[7:0] = latch_q;
            sct_pkg::IDX_HALT_CTRL: rd_mux[0] = run_halted_q;
            sct_pkg::IDX_CLK_SRC: rd_mux[1:0] = clk_src_q;
            sct_pkg::IDX_COUNT: rd_mux[15:0] = count_q;
            sct_pkg::IDX_TOP: rd_mux[15:0] = top_q;
            sct_pkg::IDX_MATCH: rd_mux[15:0] = match_q;
            sct_pkg::IDX_TICK_CTRL: rd_mux[7:0] = tick_ctrl_q;
            sct_pkg::IDX_TICK_STATUS: rd_mux[0] = pending_q[sct_pkg::SYNC_TICK]; // R13
            sct_pkg::IDX_TICK_IRQ_EN: rd_mux[0] = ten_q;
            sct_pkg::IDX_TICK_IRQ_FLAGS: rd_mux[0] = tflag_q;
            sct_pkg::IDX_TICK_HALT: rd_mux[0] = tick_run_halted_q;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // Plain bus-side registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= sct_pkg::CTRL_RESET; // R17
            tick_ctrl_q <= sct_pkg::CTRL_RESET;
            cnt_wr_q <= sct_pkg::WORD_RESET;
            top_q <= sct_pkg::TOP_RESET;
            match_q <= sct_pkg::WORD_RESET;
            cen_q <= 2'h0;
            ten_q <= 1'b0;
            latch_q <= sct_pkg::BYTE_RESET;
            run_halted_q <= 1'b0;
            tick_run_halted_q <= 1'b0;
            clk_src_q <= 2'h0;
        end else if (dp_wr_q) begin
            case (dp_idx_q)
                sct_pkg::IDX_CTRL: ctrl_q <= hwdata[7:0] & 8'hF9;
                sct_pkg::IDX_TICK_CTRL: tick_ctrl_q <= hwdata[7:0] & 8'h79;
                sct_pkg::IDX_COUNT: cnt_wr_q <= hwdata[15:0];
                sct_pkg::IDX_TOP: top_q <= hwdata[15:0];
                sct_pkg::IDX_MATCH: match_q <= hwdata[15:0];
                sct_pkg::IDX_IRQ_EN: cen_q <= hwdata[1:0]; // R6
                sct_pkg::IDX_TICK_IRQ_EN: ten_q <= hwdata[0]; // R6
                sct_pkg::IDX_BYTE_LATCH: latch_q <= hwdata[7:0];
                sct_pkg::IDX_HALT_CTRL: run_halted_q <= hwdata[sct_pkg::RUN_HALTED_BIT];
                sct_pkg::IDX_TICK_HALT: tick_run_halted_q <= hwdata[sct_pkg::RUN_HALTED_BIT];
                sct_pkg::IDX_CLK_SRC: clk_src_q <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    assign clock_source = clk_src_q;

    // Slow clock rising edge; the input is already synchronous to hclk.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_q <= 1'b0;
        end else begin
            slow_q <= slow_clk_in;
        end
    end

    assign slow_edge = slow_clk_in && !slow_q;

    // Write strobes for the registers that cross into the slow domain.
    assign sync_wr[sct_pkg::SYNC_CTRL] = dp_wr_q && dp_idx_q == sct_pkg::IDX_CTRL;
    assign sync_wr[sct_pkg::SYNC_CNT] = dp_wr_q && dp_idx_q == sct_pkg::IDX_COUNT;
    assign sync_wr[sct_pkg::SYNC_TOP] = dp_wr_q && dp_idx_q == sct_pkg::IDX_TOP;
    assign sync_wr[sct_pkg::SYNC_MATCH] = dp_wr_q && dp_idx_q == sct_pkg::IDX_MATCH;
    assign sync_wr[sct_pkg::SYNC_TICK] = dp_wr_q && dp_idx_q == sct_pkg::IDX_TICK_CTRL;

    // Each channel stays busy from the write until the second slow edge.
    for (genvar i = 0; i < NSYNC_W; i++) begin : g_sync
        logic [1:0] edges_q;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pending_q[i] <= 1'b0;
                edges_q <= 2'h0;
            end else if (sync_wr[i]) begin
                pending_q[i] <= 1'b1; // R22
                edges_q <= 2'h0;
            end else if (pending_q[i] && slow_edge) begin
                edges_q <= edges_q + 2'h1;
                if (edges_q == sct_pkg::SYNC_EDGES - 2'h1) begin
                    pending_q[i] <= 1'b0; // R16
                end
            end
        end

        assign sync_done[i] = pending_q[i] && slow_edge && edges_q == sct_pkg::SYNC_EDGES - 2'h1; // R11
    end

    // Values in effect in the slow domain.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_e_q <= sct_pkg::CTRL_RESET;
            tick_e_q <= sct_pkg::CTRL_RESET;
            top_e_q <= sct_pkg::TOP_RESET;
            match_e_q <= sct_pkg::WORD_RESET;
        end else begin
            if (sync_done[sct_pkg::SYNC_CTRL]) begin
                ctrl_e_q <= ctrl_q; // R16
            end
            if (sync_done[sct_pkg::SYNC_TICK]) begin
                tick_e_q <= tick_ctrl_q; // R11
            end
            if (sync_done[sct_pkg::SYNC_TOP]) begin
                top_e_q <= top_q;
            end
            if (sync_done[sct_pkg::SYNC_MATCH]) begin
                match_e_q <= match_q; // R18
            end
        end
    end

    // Run conditions; Idle sleep does not enter either term.
    assign counter_run = ctrl_e_q.counter_enable // R17
        && !(sleep_standby && !ctrl_e_q.keep_running_asleep) // R9
        && !(debug_halt && !run_halted_q); // R8
    assign tick_run = tick_e_q.tick_enable && !(debug_halt && !tick_run_halted_q); // R10

    // Shared prescaler runs while either function runs and restarts from zero otherwise.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 16'h0000;
        end else if (!(counter_run || tick_run)) begin
            presc_q <= 16'h0000;
        end else if (slow_edge) begin
            presc_q <= presc_q + 16'h0001;
        end
    end

    assign div_mask = 16'((17'h00001 << ctrl_e_q.prescale) - 17'h00001);
    assign div_hit = (presc_q & div_mask) == div_mask; // R15
    assign count_tick = slow_edge && counter_run && div_hit;
    assign wrap_c = count_tick && count_q == top_e_q; // R20
    assign match_c = count_tick && count_q == match_e_q; // R4

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= sct_pkg::WORD_RESET;
        end else if (sync_done[sct_pkg::SYNC_CNT]) begin
            count_q <= cnt_wr_q;
        end else if (wrap_c) begin
            count_q <= 16'h0000; // R3
        end else if (count_tick) begin
            count_q <= count_q + 16'h0001; // R21
        end
    end

    // Tick fires on each rising edge of the selected prescaler bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_bit_q <= 1'b0;
        end else begin
            tick_bit_q <= presc_q[tick_e_q.period];
        end
    end

    assign tick_hit = tick_run && presc_q[tick_e_q.period] && !tick_bit_q; // R2

    // Flags: a new event wins over a clear in the same cycle.
    assign cflag_clr = (dp_wr_q && dp_idx_q == sct_pkg::IDX_IRQ_FLAGS) ? hwdata[1:0] : 2'h0; // R19
    assign tflag_clr = dp_wr_q && dp_idx_q == sct_pkg::IDX_TICK_IRQ_FLAGS && hwdata[sct_pkg::TICK_IRQ_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cflags_q <= 2'h0;
            tflag_q <= 1'b0;
        end else begin
            cflags_q <= (cflags_q & ~cflag_clr) | {match_c, wrap_c}; // R5
            tflag_q <= (tflag_q && !tflag_clr) || tick_hit; // R5
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_event <= 1'b0;
            match_event <= 1'b0;
        end else begin
            wrap_event <= wrap_c;
            match_event <= match_c;
        end
    end

    assign irq_counter = |(cen_q & cflags_q); // R1
    assign irq_tick = ten_q && tflag_q; // R7

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_wrap_to_zero: assert property (wrap_c && !sync_done[sct_pkg::SYNC_CNT] |=> count_q == 16'h0000) // R3
        else $error("counter did not return to zero after wrap");
    a_match_sets_flag: assert property (match_c |=> cflags_q[sct_pkg::MATCH_BIT] && match_event) // R4
        else $error("match did not set its flag");
    a_flag_while_disabled: assert property (wrap_c && !cen_q[sct_pkg::WRAP_BIT] |=> cflags_q[sct_pkg::WRAP_BIT]) // R5
        else $error("disabled wrap source did not set its flag");
    a_request_holds: assert property (cen_q[0] && cflags_q[0] && !cflag_clr[0] && !dp_wr_q |=> irq_counter) // R7
        else $error("counter request dropped while flag and enable set");
    a_write_one_clears: assert property (cflag_clr[sct_pkg::WRAP_BIT] && !wrap_c // R19
        |=> !cflags_q[sct_pkg::WRAP_BIT])
        else $error("write one did not clear wrap flag");
    a_standby_stops: assert property (sleep_standby && !ctrl_e_q.keep_running_asleep |-> !count_tick) // R9
        else $error("counter advanced in standby without keep running");
    a_ctrl_busy_set: assert property (sync_wr[sct_pkg::SYNC_CTRL] |=> pending_q[sct_pkg::SYNC_CTRL]) // R22
        else $error("control busy not set by write");
    a_ctrl_applied: assert property (sync_done[sct_pkg::SYNC_CTRL] && !sync_wr[sct_pkg::SYNC_CTRL] // R16
        |=> ctrl_e_q == ctrl_q && !pending_q[sct_pkg::SYNC_CTRL])
        else $error("control value not applied when busy cleared");
    a_match_applied: assert property (sync_done[sct_pkg::SYNC_MATCH] && !sync_wr[sct_pkg::SYNC_MATCH] // R18
        |=> match_e_q == match_q && !pending_q[sct_pkg::SYNC_MATCH])
        else $error("match value not applied when busy cleared");
    a_tick_sets_flag: assert property (tick_hit |=> tflag_q) // R2
        else $error("tick did not set its flag");
    a_disabled_holds: assert property (!ctrl_e_q.counter_enable && !sync_done[sct_pkg::SYNC_CNT] // R21
        |=> $stable(count_q))
        else $error("counter moved while disabled");

endmodule // sct_slow_counter

// [sct_pkg.sv]
package sct_pkg;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_IRQ_EN = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
    localparam logic [5:0] IDX_BYTE_LATCH = 6'h04;
    localparam logic [5:0] IDX_HALT_CTRL = 6'h05;
    localparam logic [5:0] IDX_CLK_SRC = 6'h07;
    localparam logic [5:0] IDX_COUNT = 6'h08;
    localparam logic [5:0] IDX_TOP = 6'h0A;
    localparam logic [5:0] IDX_MATCH = 6'h0C;
    localparam logic [5:0] IDX_TICK_CTRL = 6'h10;
    localparam logic [5:0] IDX_TICK_STATUS = 6'h11;
    localparam logic [5:0] IDX_TICK_IRQ_EN = 6'h12;
    localparam logic [5:0] IDX_TICK_IRQ_FLAGS = 6'h13;
    localparam logic [5:0] IDX_TICK_HALT = 6'h15;

    // Byte address bits decoded by the slave.
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;

    // Field positions.
    localparam int WRAP_BIT = 0;
    localparam int MATCH_BIT = 1;
    localparam int TICK_IRQ_BIT = 0;
    localparam int RUN_HALTED_BIT = 0;

    // Synchronisation channels; 0 to 3 in the bit order of the status register, 4 is bit 0 of tick status.
    localparam int SYNC_CTRL = 0;
    localparam int SYNC_CNT = 1;
    localparam int SYNC_TOP = 2;
    localparam int SYNC_MATCH = 3;
    localparam int SYNC_TICK = 4;
    localparam int NSYNC = 5;

    // Slow clock edges from a register write until the new value acts.
    localparam logic [1:0] SYNC_EDGES = 2'h2;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] TOP_RESET = 16'hFFFF;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic keep_running_asleep;
        logic [3:0] prescale;
        logic [1:0] reserved;
        logic counter_enable;
    } sct_ctrl_t;

    typedef struct packed {
        logic reserved_hi;
        logic [3:0] period;
        logic [1:0] reserved;
        logic tick_enable;
    } sct_tick_ctrl_t;

endpackage

// [sct_slow_counter_tb_top.sv]
`timescale 1ns/10ps
module sct_slow_counter_tb_top;
    typedef struct packed {
        logic [5:0] idx;
        logic wr;
        logic [15:0] wd;
        logic [15:0] exp;
    } sct_row_t;
    // Plain register cases: optional write, then a read with the expected value.
    localparam sct_row_t ROWS [11] = '{
        '{sct_pkg::IDX_CTRL, 1'b0, 16'h0000, 16'h0000},
        '{sct_pkg::IDX_STATUS, 1'b0, 16'h0000, 16'h0000},
        '{sct_pkg::IDX_TICK_STATUS, 1'b0, 16'h0000, 16'h0000},
        '{sct_pkg::IDX_TOP, 1'b0, 16'h0000, 16'hFFFF},
        '{sct_pkg::IDX_IRQ_FLAGS, 1'b0, 16'h0000, 16'h0000},
        '{sct_pkg::IDX_IRQ_EN, 1'b1, 16'h0003, 16'h0003},
        '{sct_pkg::IDX_TICK_IRQ_EN, 1'b1, 16'h0001, 16'h0001},
        '{sct_pkg::IDX_CLK_SRC, 1'b1, 16'h0002, 16'h0002},
        '{sct_pkg::IDX_BYTE_LATCH, 1'b1, 16'h00A5, 16'h00A5},
        '{sct_pkg::IDX_STATUS, 1'b1, 16'h000F, 16'h0000},
        '{6'h06, 1'b1, 16'h00FF, 16'h0000}
    };
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic slow_clk_in = 1'b0;
    logic sleep_idle = 1'b0;
    logic sleep_standby = 1'b0;
    logic hreadyout, hresp, irq_counter, irq_tick, wrap_event, match_event;
    logic [31:0] hrdata;
    logic [1:0] clock_source;
    logic [31:0] rd;
    logic [2:0] slow_div = 3'h0;
    int error_cnt = 0;
    int checks = 0;
    int n;

    sct_slow_counter dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .slow_clk_in(slow_clk_in), .sleep_idle(sleep_idle),
        .sleep_standby(sleep_standby), .debug_halt(1'b0), .irq_counter(irq_counter), .irq_tick(irq_tick),
        .wrap_event(wrap_event), .match_event(match_event), .clock_source(clock_source));

    always #4 hclk = ~hclk;

    // The slow count clock has one rising edge every eight system clocks.
    always @(posedge hclk) begin
        slow_div <= slow_div + 3'h1;
        slow_clk_in <= slow_div[2];
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Summary: %0d checks, %0d mismatches", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic ready_edge;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                error_cnt++;
                $display("CHECK FAILED at %0t: bus wait ran out", $time);
                end_sim;
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic [5:0] idx, input logic wr, input logic [15:0] wd, output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {24'h000000, idx, 2'h0};
        htrans <= sct_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        ready_edge;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        ready_edge;
        rdv = hrdata;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        bus(idx, 1'b1, d, rd);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp, input string msg);
        bus(idx, 1'b0, 16'h0000, rd);
        check(rd, {16'h0000, exp}, msg);
    endtask

    // Writes a synchronised register, then polls its busy bit the way software must.
    task automatic wr_sync(input logic [5:0] idx, input logic [15:0] d, input logic tk, input int b);
        int k;
        logic [5:0] sidx;
        sidx = tk ? sct_pkg::IDX_TICK_STATUS : sct_pkg::IDX_STATUS;
        wr(idx, d);
        bus(sidx, 1'b0, 16'h0000, rd);
        check({31'h0, rd[b]}, 32'h1, "busy right after write");
        k = 0;
        while (rd[b] !== 1'b0 && k < 10) begin
            bus(sidx, 1'b0, 16'h0000, rd);
            k++;
        end
        check({31'h0, rd[b]}, 32'h0, "busy clears after two slow edges");
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return wrap_event;
            1: return match_event;
            2: return irq_tick;
            default: return irq_counter;
        endcase
    endfunction

    // Counts system clocks until the chosen signal is seen high; -1 if the bound runs out.
    // Samples at the falling edge, where outputs have settled, then returns on a rising edge.
    task automatic wait_sig(input int w, input int bound, output int cyc);
        cyc = 0;
        do begin
            @(negedge hclk);
            cyc++;
        end while (sig(w) !== 1'b1 && cyc < bound);
        if (sig(w) !== 1'b1)
            cyc = -1;
        @(posedge hclk);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ROWS[i]) begin
            if (ROWS[i].wr)
                wr(ROWS[i].idx, ROWS[i].wd);
            bus(ROWS[i].idx, 1'b0, 16'h0000, rd);
            check(rd, {16'h0000, ROWS[i].exp}, "register row");
        end
        check({30'h0, clock_source}, 32'h2, "clock source output");
        check({31'h0, hresp}, 32'h0, "response always okay");
        $display("Test register table done");

        wr_sync(sct_pkg::IDX_TOP, 16'h0007, 1'b0, sct_pkg::SYNC_TOP);
        wr_sync(sct_pkg::IDX_MATCH, 16'h0005, 1'b0, sct_pkg::SYNC_MATCH);
        wr_sync(sct_pkg::IDX_COUNT, 16'h0000, 1'b0, sct_pkg::SYNC_CNT);
        for (int p = 0; p < 3; p++) begin
            wr_sync(sct_pkg::IDX_CTRL, 16'(8 * p + 1), 1'b0, sct_pkg::SYNC_CTRL);
            wait_sig(0, 2000, n);
            wait_sig(0, 2000, n);
            check(n, 64 << p, "wrap interval");
        end
        $display("Test prescaled counting done");

        rdchk(sct_pkg::IDX_IRQ_FLAGS, 16'h0003, "wrap and match flags");
        check({31'h0, irq_counter}, 32'h1, "counter request");
        wr(sct_pkg::IDX_IRQ_FLAGS, 16'h0001);
        rdchk(sct_pkg::IDX_IRQ_FLAGS, 16'h0002, "write one clears wrap");
        wr(sct_pkg::IDX_IRQ_FLAGS, 16'h0000);
        rdchk(sct_pkg::IDX_IRQ_FLAGS, 16'h0002, "write zero keeps flag");
        wr(sct_pkg::IDX_IRQ_FLAGS, 16'h0002);
        rdchk(sct_pkg::IDX_IRQ_FLAGS, 16'h0000, "match cleared");
        check({31'h0, irq_counter}, 32'h0, "request drops with flags");
        wr(sct_pkg::IDX_IRQ_EN, 16'h0000);
        wait_sig(1, 600, n);
        rdchk(sct_pkg::IDX_IRQ_FLAGS, 16'h0002, "flag set while disabled");
        check({31'h0, irq_counter}, 32'h0, "no request while disabled");
        wr(sct_pkg::IDX_IRQ_EN, 16'h0002);
        @(posedge hclk);
        check({31'h0, irq_counter}, 32'h1, "request after enable");
        wr(sct_pkg::IDX_IRQ_FLAGS, 16'h0003);
        $display("Test flags and requests done");

        sleep_standby <= 1'b1;
        wait_sig(0, 1100, n);
        check(n, -1, "counter stopped in standby");
        wr_sync(sct_pkg::IDX_TICK_CTRL, 16'h0019, 1'b1, 0);
        wr(sct_pkg::IDX_TICK_IRQ_FLAGS, 16'h0001);
        wait_sig(2, 300, n);
        check({31'h0, irq_tick}, 32'h1, "tick request in standby");
        wr(sct_pkg::IDX_TICK_IRQ_FLAGS, 16'h0001);
        wait_sig(2, 300, n);
        check(n, 126, "tick interval");
        wr_sync(sct_pkg::IDX_CTRL, 16'h0091, 1'b0, sct_pkg::SYNC_CTRL);
        wait_sig(0, 1100, n);
        check({31'h0, n > 0}, 32'h1, "counter runs in standby when kept");
        sleep_standby <= 1'b0;
        sleep_idle <= 1'b1;
        wr_sync(sct_pkg::IDX_CTRL, 16'h0011, 1'b0, sct_pkg::SYNC_CTRL);
        wait_sig(0, 1100, n);
        check({31'h0, n > 0}, 32'h1, "counter runs in idle");
        $display("Test sleep modes done");

        wr_sync(sct_pkg::IDX_CTRL, 16'h0006, 1'b0, sct_pkg::SYNC_CTRL);
        rdchk(sct_pkg::IDX_CTRL, 16'h0000, "reserved control bits read zero");
        wr_sync(sct_pkg::IDX_COUNT, 16'h0003, 1'b0, sct_pkg::SYNC_CNT);
        repeat (100) @(posedge hclk);
        rdchk(sct_pkg::IDX_COUNT, 16'h0003, "count holds while disabled");
        $display("Test disable and hold done");

        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        check({30'h0, irq_tick, irq_counter}, 32'h0, "requests low in reset");
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(sct_pkg::IDX_CTRL, 16'h0000, "control after reset");
        rdchk(sct_pkg::IDX_TOP, 16'hFFFF, "top after reset");
        rdchk(sct_pkg::IDX_STATUS, 16'h0000, "status after reset");
        $display("Test second reset done");
        end_sim;
    end
endmodule // sct_slow_counter_tb_top
